// *** rtl/sync_holdover_map.svh ***
// Register numbers, field positions, reset values and timing constants
`ifndef SYNC_HOLDOVER_MAP_SVH
`define SYNC_HOLDOVER_MAP_SVH

`define REG_SYNC_CFG   5'h0B
`define REG_LOCK_CFG   5'h0C
`define REG_HOLD_CFG   5'h0D
`define REG_LOSS_CFG   5'h0E
`define REG_READBACK   5'h1F
`define REG_LAST_DIV   5'h05

`define RST_SYNC_CFG   32'h0181_0000
`define RST_LOCK_CFG   32'h1800_0180
`define RST_HOLD_CFG   32'h0000_06E0
`define RST_LOSS_CFG   32'h1000_0000
`define MSK_SYNC_CFG   32'h03FF_8020
`define MSK_LOCK_CFG   32'hF8C0_01C0
`define MSK_HOLD_CFG   32'h0070_FFE0
`define MSK_LOSS_CFG   32'hD000_0000

`define ADDR_HI        4
`define RB_SEL_HI      9
`define RB_SEL_LO      5
`define EXCL_HI        25
`define EXCL_LO        20
`define ALIGN_SRC_HI   19
`define ALIGN_SRC_LO   18
`define ALIGN_QUAL     17
`define ALIGN_POL      16
`define ALIGN_AUTO     15
`define XTAL_EN        5
`define LOCK_SRC_HI    31
`define LOCK_SRC_LO    27
`define HOLD_L2        23
`define HOLD_L1        22
`define DAC_TRACK      8
`define HO_MODE_HI     7
`define HO_MODE_LO     6
`define HO_MODE_AUTO   2'h2
`define ST1_SRC_HI     22
`define ST1_SRC_LO     20
`define L1_MASK        15
`define ST0_SRC_HI     14
`define ST0_SRC_LO     12
`define REF_MODE_HI    11
`define REF_MODE_LO    9
`define SEL_INV        8
`define USABLE_HI      7
`define USABLE_LO      5
`define LOS_TO_HI      31
`define LOS_TO_LO      30
`define LOS_EN         28

`define REF_MODE_FIX0  3'h0
`define REF_MODE_FIX1  3'h1
`define REF_MODE_FIX2  3'h2
`define REF_MODE_MAN   3'h3
`define REF_MODE_AUTO  3'h4

`define SRC_LOW        5'h00
`define SRC_LOOP1      5'h01
`define SRC_LOOP2      5'h02
`define SRC_BOTH       5'h03
`define SRC_HOLDOVER   5'h04
`define SRC_ALIGN      5'h05
`define SRC_REF_OK     5'h06
`define SRC_ANY_LOSS   5'h07

`define CLK_PERIOD_NS  25
`define LOS_T0_NS      1200
`define LOS_T1_NS      2400
`define LOS_T2_NS      4800
`define LOS_T3_NS      9600
`define LOS_CNT_W      9

`endif

// *** rtl/sync_holdover_pkg.sv ***
// Shared types for the configuration bank
package sync_holdover_pkg;

	typedef struct packed {
		logic sclk;
		logic sdata;
		logic latch;
	} prog_s;

	typedef struct packed {
		logic loop1;
		logic loop2;
	} lock_s;

	typedef enum logic [2:0] {
		AL_IDLE = 3'h1,
		AL_ACTIVE = 3'h2,
		AL_WAIT = 3'h4
	} align_state_e;

	typedef logic [31:0] word_t;

endpackage

// *** rtl/signal_loss_monitor.sv ***
// Activity watchdog for one reference input
`timescale 1ns/10ps
`include "sync_holdover_map.svh"
module signal_loss_monitor (
	input  wire logic                  clk_i,
	input  wire logic                  srst_i,
	input  wire logic                  ref_i,
	input  wire logic                  enable_i,
	input  wire logic [`LOS_CNT_W-1:0] limit_i,
	output logic                       loss_o
);
	logic                  ref_q;
	logic [`LOS_CNT_W-1:0] idle_cnt;
	wire                   edge_seen;
	wire                   expired;

	// Either edge counts as activity
	assign edge_seen = ref_i ^ ref_q;
	assign expired = (idle_cnt >= limit_i);

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ref_q <= 1'b0;
			idle_cnt <= '0;
			loss_o <= 1'b0;
		end else begin
			ref_q <= ref_i;
			if (!enable_i || edge_seen) begin
				idle_cnt <= '0;
			end else if (!expired) begin
				idle_cnt <= idle_cnt + `LOS_CNT_W'(1);
			end
			loss_o <= enable_i && expired && !edge_seen;
		end
	end
endmodule

// *** rtl/sync_holdover_clkin_config_bank.sv ***
// Configuration bank for alignment, holdover, reference select and loss
`timescale 1ns/10ps
`include "sync_holdover_map.svh"
module sync_holdover_clkin_config_bank (
	input  wire logic                     clk_i,
	input  wire logic                     srst_i,
	input  wire sync_holdover_pkg::prog_s prog_i,
	input  wire logic                     align_pin_i,
	input  wire sync_holdover_pkg::lock_s lock_i,
	input  wire logic [2:0]               ref_i,
	input  wire logic [1:0]               status_pin_i,
	output logic                          readback_o,
	output logic [5:0]                    out_align_o,
	output logic                          align_active_o,
	output logic                          align_qualify_o,
	output logic                          align_pin_o,
	output logic                          lock_pin_o,
	output logic [1:0]                    status_pin_o,
	output logic                          holdover_o,
	output logic [1:0]                    ref_select_o,
	output logic                          ref_valid_o,
	output logic [2:0]                    signal_loss_o,
	output logic                          crystal_osc_enable_o,
	output logic                          dac_track_o
);
	// Least times round up to whole cycles
	function automatic logic [`LOS_CNT_W-1:0] ns_to_cycles(
		input int ns
	);
		int c;
		c = (ns + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
		if (c < 1) begin
			c = 1;
		end
		return c[`LOS_CNT_W-1:0];
	endfunction

	// Only listed fields take a write; reserved bits keep reset state
	function automatic sync_holdover_pkg::word_t merge(
		input sync_holdover_pkg::word_t cur,
		input sync_holdover_pkg::word_t wdata,
		input sync_holdover_pkg::word_t mask
	);
		return (wdata & mask) | (cur & ~mask);
	endfunction

	// Shared source selector for every status-type pin
	function automatic logic pick_source(
		input logic [4:0] sel,
		input logic       l1,
		input logic       l2,
		input logic       ho,
		input logic       al,
		input logic       rok,
		input logic       anyl
	);
		logic v;
		v = 1'b0;
		case (sel)
			`SRC_LOOP1:    v = l1;
			`SRC_LOOP2:    v = l2;
			`SRC_BOTH:     v = l1 & l2;
			`SRC_HOLDOVER: v = ho;
			`SRC_ALIGN:    v = al;
			`SRC_REF_OK:   v = rok;
			`SRC_ANY_LOSS: v = anyl;
			default:       v = 1'b0;
		endcase
		return v;
	endfunction

	sync_holdover_pkg::word_t sync_and_oscillator_config;
	sync_holdover_pkg::word_t lock_detect_and_tracking_config;
	sync_holdover_pkg::word_t holdover_and_input_select_config;
	sync_holdover_pkg::word_t input_loss_detect_config;
	sync_holdover_pkg::word_t shift_in;
	sync_holdover_pkg::word_t rb_shift;
	sync_holdover_pkg::align_state_e align_state;
	sync_holdover_pkg::align_state_e next_align_state;
	logic       sclk_q;
	logic       latch_q;
	logic       loop1_q;
	logic [1:0] ref_idx;
	logic       ref_ok;
	logic [2:0] loss;

	// Serial programming port, sampled on the system clock
	wire        sclk_rise = prog_i.sclk & ~sclk_q;
	wire        latch_rise = prog_i.latch & ~latch_q;
	wire [4:0]  addr = shift_in[`ADDR_HI:0];
	wire        wr_sync = latch_rise && (addr == `REG_SYNC_CFG);
	wire        wr_lock = latch_rise && (addr == `REG_LOCK_CFG);
	wire        wr_hold = latch_rise && (addr == `REG_HOLD_CFG);
	wire        wr_loss = latch_rise && (addr == `REG_LOSS_CFG);
	wire        rb_load = latch_rise && (addr == `REG_READBACK);
	wire        div_write = latch_rise && (addr <= `REG_LAST_DIV);
	wire [4:0]  rb_sel = shift_in[`RB_SEL_HI:`RB_SEL_LO];
	wire sync_holdover_pkg::word_t rb_word =
		(rb_sel == `REG_SYNC_CFG) ? sync_and_oscillator_config :
		(rb_sel == `REG_LOCK_CFG) ? lock_detect_and_tracking_config :
		(rb_sel == `REG_HOLD_CFG) ? holdover_and_input_select_config :
		(rb_sel == `REG_LOSS_CFG) ? input_loss_detect_config :
		32'h0000_0000;

	// Field taps
	wire [5:0] excl = sync_and_oscillator_config[`EXCL_HI:`EXCL_LO];
	wire [1:0] align_src =
		sync_and_oscillator_config[`ALIGN_SRC_HI:`ALIGN_SRC_LO];
	wire       align_pol = sync_and_oscillator_config[`ALIGN_POL];
	wire       align_auto = sync_and_oscillator_config[`ALIGN_AUTO];
	wire [4:0] lock_src =
		lock_detect_and_tracking_config[`LOCK_SRC_HI:`LOCK_SRC_LO];
	wire       hold_l2 = lock_detect_and_tracking_config[`HOLD_L2];
	wire       hold_l1 = lock_detect_and_tracking_config[`HOLD_L1];
	wire [1:0] ho_mode =
		lock_detect_and_tracking_config[`HO_MODE_HI:`HO_MODE_LO];
	wire [2:0] st1_src =
		holdover_and_input_select_config[`ST1_SRC_HI:`ST1_SRC_LO];
	wire [2:0] st0_src =
		holdover_and_input_select_config[`ST0_SRC_HI:`ST0_SRC_LO];
	wire       l1_mask = holdover_and_input_select_config[`L1_MASK];
	wire [2:0] ref_mode =
		holdover_and_input_select_config[`REF_MODE_HI:`REF_MODE_LO];
	wire       sel_inv = holdover_and_input_select_config[`SEL_INV];
	wire [2:0] usable =
		holdover_and_input_select_config[`USABLE_HI:`USABLE_LO];
	wire [1:0] los_to = input_loss_detect_config[`LOS_TO_HI:`LOS_TO_LO];
	wire       los_en = input_loss_detect_config[`LOS_EN];

	// Alignment request and lock gating
	wire align_req = align_pol ? ~align_pin_i : align_pin_i;
	wire auto_req = div_write & align_auto;
	wire lock_wait = (hold_l2 & ~lock_i.loop2) |
		(hold_l1 & ~lock_i.loop1);
	wire align_on = (align_state != sync_holdover_pkg::AL_IDLE);

	// Reference choice
	wire [1:0] man_idx = status_pin_i ^ {2{sel_inv}};
	wire [1:0] auto_idx =
		(usable[0] & ~loss[0]) ? 2'h0 :
		(usable[1] & ~loss[1]) ? 2'h1 :
		(usable[2] & ~loss[2]) ? 2'h2 : 2'h3;
	wire [1:0] next_ref_idx =
		(ref_mode == `REF_MODE_FIX0) ? 2'h0 :
		(ref_mode == `REF_MODE_FIX1) ? 2'h1 :
		(ref_mode == `REF_MODE_FIX2) ? 2'h2 :
		(ref_mode == `REF_MODE_MAN)  ? man_idx :
		(ref_mode == `REF_MODE_AUTO) ? auto_idx : 2'h3;
	// Index 3 names no input, so it is never valid
	wire next_ref_ok = (next_ref_idx != 2'h3) &&
		usable[next_ref_idx];
	wire sel_loss = (ref_idx != 2'h3) && loss[ref_idx];

	// Holdover entry and exit
	wire l1_fall = loop1_q & ~lock_i.loop1;
	wire ho_auto = (ho_mode == `HO_MODE_AUTO);
	wire ho_enter = ho_auto & ((l1_fall & ~l1_mask) | sel_loss);
	wire ho_exit = lock_i.loop1 & ~sel_loss;

	// Loss timeout choice
	wire [`LOS_CNT_W-1:0] los_limit =
		(los_to == 2'h0) ? ns_to_cycles(`LOS_T0_NS) :
		(los_to == 2'h1) ? ns_to_cycles(`LOS_T1_NS) :
		(los_to == 2'h2) ? ns_to_cycles(`LOS_T2_NS) :
		ns_to_cycles(`LOS_T3_NS);

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_los
			signal_loss_monitor u_mon (
				.clk_i   (clk_i),
				.srst_i  (srst_i),
				.ref_i   (ref_i[g]),
				.enable_i(los_en),
				.limit_i (los_limit),
				.loss_o  (loss[g])
			);
		end
	endgenerate

	always_comb begin
		next_align_state = align_state;
		unique case (align_state)
			sync_holdover_pkg::AL_IDLE: begin
				if (align_req || auto_req) begin
					next_align_state = sync_holdover_pkg::AL_ACTIVE;
				end else if (lock_wait) begin
					next_align_state = sync_holdover_pkg::AL_WAIT;
				end
			end
			sync_holdover_pkg::AL_ACTIVE: begin
				if (!align_req && lock_wait) begin
					next_align_state = sync_holdover_pkg::AL_WAIT;
				end else if (!align_req) begin
					next_align_state = sync_holdover_pkg::AL_IDLE;
				end
			end
			sync_holdover_pkg::AL_WAIT: begin
				if (align_req || auto_req) begin
					next_align_state = sync_holdover_pkg::AL_ACTIVE;
				end else if (!lock_wait) begin
					next_align_state = sync_holdover_pkg::AL_IDLE;
				end
			end
			default: begin
				next_align_state = sync_holdover_pkg::AL_IDLE;
			end
		endcase
	end

	// Serial capture and readback shifter
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			sclk_q <= 1'b0;
			latch_q <= 1'b0;
			shift_in <= '0;
			rb_shift <= '0;
		end else begin
			sclk_q <= prog_i.sclk;
			latch_q <= prog_i.latch;
			if (sclk_rise && !prog_i.latch) begin
				shift_in <= {shift_in[30:0], prog_i.sdata};
			end
			if (rb_load) begin
				rb_shift <= rb_word;
			end else if (sclk_rise && !prog_i.latch) begin
				rb_shift <= {rb_shift[30:0], 1'b0};
			end
		end
	end

	// Register file
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			sync_and_oscillator_config <= `RST_SYNC_CFG;
			lock_detect_and_tracking_config <= `RST_LOCK_CFG;
			holdover_and_input_select_config <= `RST_HOLD_CFG;
			input_loss_detect_config <= `RST_LOSS_CFG;
		end else begin
			if (wr_sync) begin
				sync_and_oscillator_config <= merge(
					sync_and_oscillator_config, shift_in,
					`MSK_SYNC_CFG);
			end
			if (wr_lock) begin
				lock_detect_and_tracking_config <= merge(
					lock_detect_and_tracking_config, shift_in,
					`MSK_LOCK_CFG);
			end
			if (wr_hold) begin
				holdover_and_input_select_config <= merge(
					holdover_and_input_select_config, shift_in,
					`MSK_HOLD_CFG);
			end
			if (wr_loss) begin
				input_loss_detect_config <= merge(
					input_loss_detect_config, shift_in,
					`MSK_LOSS_CFG);
			end
		end
	end

	// Alignment, holdover and reference state
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			align_state <= sync_holdover_pkg::AL_IDLE;
			loop1_q <= 1'b0;
			ref_idx <= 2'h3;
			ref_ok <= 1'b0;
			holdover_o <= 1'b0;
		end else begin
			align_state <= next_align_state;
			loop1_q <= lock_i.loop1;
			ref_idx <= next_ref_idx;
			ref_ok <= next_ref_ok;
			// Entry wins over exit when both appear together
			if (!ho_auto) begin
				holdover_o <= 1'b0;
			end else if (ho_enter) begin
				holdover_o <= 1'b1;
			end else if (ho_exit) begin
				holdover_o <= 1'b0;
			end
		end
	end

	// Registered pin and control outputs
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			out_align_o <= 6'h00;
			align_active_o <= 1'b0;
			align_qualify_o <= 1'b0;
			align_pin_o <= 1'b0;
			lock_pin_o <= 1'b0;
			status_pin_o <= 2'h0;
			crystal_osc_enable_o <= 1'b0;
			dac_track_o <= 1'b0;
			signal_loss_o <= 3'h0;
		end else begin
			out_align_o <= align_on ? ~excl : 6'h00;
			align_active_o <= align_on;
			align_qualify_o <=
				sync_and_oscillator_config[`ALIGN_QUAL];
			align_pin_o <= pick_source({3'h0, align_src},
				lock_i.loop1, lock_i.loop2, holdover_o, align_on,
				ref_ok, |loss);
			lock_pin_o <= pick_source(lock_src,
				lock_i.loop1, lock_i.loop2, holdover_o, align_on,
				ref_ok, |loss);
			status_pin_o[0] <= pick_source({2'h0, st0_src},
				lock_i.loop1, lock_i.loop2, holdover_o, align_on,
				ref_ok, |loss);
			status_pin_o[1] <= pick_source({2'h0, st1_src},
				lock_i.loop1, lock_i.loop2, holdover_o, align_on,
				ref_ok, |loss);
			crystal_osc_enable_o <=
				sync_and_oscillator_config[`XTAL_EN];
			dac_track_o <=
				lock_detect_and_tracking_config[`DAC_TRACK];
			signal_loss_o <= loss;
		end
	end

	// Selection is registered once more through ref_idx
	assign ref_select_o = ref_idx;
	assign ref_valid_o = ref_ok;
	// Readback bit is the shifter's top flop
	assign readback_o = rb_shift[31];
endmodule

// *** tb/cfg_bank_chk.sv ***
// Port-level assertions for the configuration bank
`timescale 1ns/10ps
module cfg_bank_chk (
	input wire logic                     clk_i,
	input wire logic                     srst_i,
	input wire sync_holdover_pkg::lock_s lock_i,
	input wire logic [2:0]               ref_i,
	input wire logic [5:0]               out_align_o,
	input wire logic                     align_active_o,
	input wire logic                     align_qualify_o,
	input wire logic                     lock_pin_o,
	input wire logic                     holdover_o,
	input wire logic [1:0]               ref_select_o,
	input wire logic                     ref_valid_o,
	input wire logic [2:0]               signal_loss_o,
	input wire logic                     crystal_osc_enable_o,
	input wire logic                     dac_track_o
);
	// Shortest limit is 48; slack left for input sampling stages
	localparam int MIN_IDLE = 44;
	logic       ref0_q;
	logic [8:0] idle0;
	logic [3:0] cause_q;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);
	always_ff @(posedge clk_i) begin
		ref0_q <= ref_i[0];
		cause_q <= srst_i ? 4'h0 :
			{cause_q[2:0], ~lock_i.loop1 | |signal_loss_o};
		if (srst_i || ref_i[0] != ref0_q)
			idle0 <= 9'h000;
		else if (idle0 != 9'h1FF)
			idle0 <= idle0 + 9'h001;
	end
	sequence ref0_moves;
		ref_i[0] != ref0_q;
	endsequence
	sequence ho_cause;
		!lock_i.loop1 || |signal_loss_o || |cause_q;
	endsequence
	a_track_after_reset: assert property ($fell(srst_i) |=>
		dac_track_o)
		else $error("dac tracking off after reset");
	a_osc_qual_reset: assert property ($fell(srst_i) |=>
		!crystal_osc_enable_o && !align_qualify_o)
		else $error("oscillator or qualify on after reset");
	a_lock_pin_reset: assert property ($fell(srst_i) |=>
		lock_pin_o == &$past(lock_i))
		else $error("lock pin not both locks after reset");
	a_align_needs_active: assert property (|out_align_o |->
		align_active_o)
		else $error("output aligned while alignment idle");
	a_valid_has_ref: assert property (ref_valid_o |->
		ref_select_o != 2'h3)
		else $error("valid without a chosen reference");
	a_loss_after_idle: assert property ($rose(signal_loss_o[0]) |->
		idle0 >= MIN_IDLE)
		else $error("loss raised before idle timeout");
	a_loss_clears: assert property (signal_loss_o[0] ##0 ref0_moves |->
		##[1:4] !signal_loss_o[0])
		else $error("loss kept after input activity");
	a_holdover_cause: assert property ($rose(holdover_o) |-> ho_cause)
		else $error("holdover entered without a cause");
	a_holdover_exit: assert property ($fell(holdover_o) |->
		lock_i.loop1 || $past(lock_i.loop1) || $past(lock_i.loop1, 2))
		else $error("holdover left while unlocked");
endmodule

bind sync_holdover_clkin_config_bank cfg_bank_chk cfg_bank_chk_inst (
	.clk_i, .srst_i, .lock_i, .ref_i, .out_align_o, .align_active_o,
	.align_qualify_o, .lock_pin_o, .holdover_o, .ref_select_o, .ref_valid_o,
	.signal_loss_o, .crystal_osc_enable_o, .dac_track_o
);

// *** tb/host_prog_model.sv ***
// Behavioural host driving the serial programming port
`timescale 1ns/10ps
module host_prog_model (
	input  wire logic                clk_i,
	input  wire logic                readback_i,
	output sync_holdover_pkg::prog_s prog_o
);
	// Cycles per clock level; 3 gives a slower host
	int hold = 2;
	initial prog_o = '0;
	task automatic send(input logic [31:0] w);
		for (int i = 31; i >= 0; i--) begin
			prog_o.sdata <= w[i];
			prog_o.sclk <= 1'b0;
			repeat (hold) @(posedge clk_i);
			prog_o.sclk <= 1'b1;
			repeat (hold) @(posedge clk_i);
		end
		// Data not held after the frame, so show the inverse
		prog_o.sdata <= ~w[0];
		prog_o.sclk <= 1'b0;
		prog_o.latch <= 1'b1;
		repeat (hold) @(posedge clk_i);
		prog_o.latch <= 1'b0;
		repeat (hold) @(posedge clk_i);
	endtask
	task automatic fetch(input logic [4:0] s, output logic [31:0] r);
		send({22'h000000, s, 5'h1F});
		r[31] = readback_i;
		for (int i = 30; i >= 0; i--) begin
			prog_o.sclk <= 1'b0;
			repeat (hold) @(posedge clk_i);
			prog_o.sclk <= 1'b1;
			repeat (hold) @(posedge clk_i);
			r[i] = readback_i;
		end
		prog_o.sclk <= 1'b0;
		@(posedge clk_i);
	endtask
endmodule

// *** tb/tb.sv ***
// Self-checking bench for the configuration bank
`timescale 1ns/10ps
module tb;
	logic                     clk = 1'b0;
	logic                     srst = 1'b1;
	sync_holdover_pkg::prog_s prog;
	logic                     align_pin = 1'b1;
	sync_holdover_pkg::lock_s lock = 2'b11;
	logic [2:0]               refs = 3'h0;
	logic [2:0]               toggle = 3'h7;
	logic [1:0]               status = 2'h0;
	logic                     rb, al_act, al_q, al_pin, lk_pin, ho, rval;
	logic                     xtal, track;
	logic [5:0]               out_align;
	logic [1:0]               st_pin, rsel;
	logic [2:0]               loss;
	logic [31:0]              mreg [11:14];
	logic [31:0]              msk [11:14];
	logic [31:0]              r;
	int                       seed = 92206;
	int                       acts = 0;
	int                       a0;
	int                       miscompares = 0;
	int                       comparisons = 0;
	sync_holdover_clkin_config_bank sync_holdover_clkin_config_bank_inst (
		.clk_i(clk), .srst_i(srst), .prog_i(prog), .align_pin_i(align_pin),
		.lock_i(lock), .ref_i(refs), .status_pin_i(status), .readback_o(rb),
		.out_align_o(out_align), .align_active_o(al_act),
		.align_qualify_o(al_q), .align_pin_o(al_pin), .lock_pin_o(lk_pin),
		.status_pin_o(st_pin), .holdover_o(ho), .ref_select_o(rsel),
		.ref_valid_o(rval), .signal_loss_o(loss),
		.crystal_osc_enable_o(xtal), .dac_track_o(track)
	);
	host_prog_model host_prog_model_inst (
		.clk_i(clk), .readback_i(rb), .prog_o(prog)
	);
	always #12.5 clk = ~clk;
	always @(posedge clk) begin
		refs <= refs ^ toggle;
		acts <= acts + int'(al_act === 1'b1);
	end
	task automatic end_sim();
		if (miscompares == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] got,
		input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic rst();
		srst <= 1'b1;
		lock <= 2'b11;
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		mreg[11] = 32'h0181_0000;
		mreg[12] = 32'h1800_0180;
		mreg[13] = 32'h0000_06E0;
		mreg[14] = 32'h1000_0000;
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		host_prog_model_inst.send({d[31:5], a});
		if (a > 5'h0A && a < 5'h0F)
			mreg[a] = (mreg[a] & ~msk[a]) | (d & msk[a]);
		check("xtal", xtal, mreg[11][5]);
		check("qualify", al_q, mreg[11][17]);
		check("track", track, mreg[12][8]);
	endtask
	task automatic rd(input int a);
		host_prog_model_inst.fetch(a[4:0], r);
		check("readback", r, (a > 10 && a < 15) ? mreg[a] : 32'h0);
	endtask
	function automatic logic src(input int c);
		return c == 1 ? lock.loop1 : c == 2 ? lock.loop2 :
			c == 3 ? lock.loop1 & lock.loop2 : 1'b0;
	endfunction
	initial begin
		msk[11] = 32'h03FF_8020;
		msk[12] = 32'hF8C0_01C0;
		msk[13] = 32'h0070_FFE0;
		msk[14] = 32'hD000_0000;
		@(posedge clk);
		rst();
		for (int a = 11; a < 15; a++) rd(a);
		for (int k = 0; k < 12; k++) begin
			host_prog_model_inst.hold = 2 + k % 2;
			wr(5'h0B + 5'(k % 4), $random(seed));
			rd(11 + k % 4);
		end
		wr(5'h10, 32'hFFFF_FFE0);
		rd(11);
		rd(2);
		// Second reset in mid-run
		rst();
		align_pin <= 1'b0;
		repeat (4) @(posedge clk);
		check("align", out_align, 6'h27);
		align_pin <= 1'b1;
		repeat (4) @(posedge clk);
		check("align idle", out_align, 6'h00);
		wr(5'h0B, 32'h02A1_0000);
		align_pin <= 1'b0;
		repeat (4) @(posedge clk);
		check("align excl", out_align, 6'h15);
		align_pin <= 1'b1;
		wr(5'h0B, 32'h0000_0000);
		repeat (4) @(posedge clk);
		check("align pol", al_act, 1'b1);
		for (int m = 0; m < 3; m++) begin
			wr(5'h0B, m == 0 ? 32'h0001_0000 : 32'h0001_8000);
			a0 = acts;
			wr(m == 2 ? 5'h06 : 5'h05, 32'h0);
			check("auto align", acts > a0, m == 1);
		end
		for (int c = 0; c < 4; c++) begin
			lock <= 2'($random(seed));
			wr(5'h0B, 32'h0001_0000 | 32'(c) << 18);
			check("align pin", al_pin, src(c));
			wr(5'h0C, 32'(c) << 27 | 32'h0000_0180);
			check("lock pin", lk_pin, src(c));
			wr(5'h0D, 32'(c) * 32'h0010_1000 | 32'h0000_06E0);
			check("status pins", st_pin, {2{src(c)}});
		end
		status <= 2'h2;
		wr(5'h0D, 32'h0000_06E0);
		check("ref sel", rsel, 2'h2);
		check("ref ok", rval, 1'b1);
		wr(5'h0D, 32'h0000_07A0);
		check("ref sel inv", rsel, 2'h1);
		check("ref unusable", rval, 1'b0);
		wr(5'h0D, 32'h0000_08C0);
		check("ref auto", rsel, 2'h1);
		check("ref auto ok", rval, 1'b1);
		for (int t = 0; t < 2; t++) begin
			wr(5'h0E, 32'h1000_0000 | 32'(t) << 30);
			toggle <= 3'h6;
			repeat ((48 << t) - 4) @(posedge clk);
			check("loss early", loss[0], 1'b0);
			repeat (10) @(posedge clk);
			check("loss", loss[0], 1'b1);
			toggle <= 3'h7;
		end
		wr(5'h0E, 32'h0000_0000);
		toggle <= 3'h6;
		repeat (60) @(posedge clk);
		check("loss off", loss, 3'h0);
		lock <= 2'b11;
		repeat (4) @(posedge clk);
		check("no holdover", ho, 1'b0);
		lock <= 2'b01;
		repeat (4) @(posedge clk);
		check("holdover", ho, 1'b1);
		lock <= 2'b11;
		wr(5'h0D, 32'h0000_86E0);
		check("holdover exit", ho, 1'b0);
		lock <= 2'b01;
		repeat (4) @(posedge clk);
		check("holdover masked", ho, 1'b0);
		for (int h = 0; h < 2; h++) begin
			lock <= h ? 2'b10 : 2'b01;
			wr(5'h0C, 32'h1800_0180 | 32'h0040_0000 << h);
			check("align hold", al_act, 1'b1);
			check("align hold out", out_align, 6'h3F);
			lock <= 2'b11;
			repeat (4) @(posedge clk);
			check("align released", al_act, 1'b0);
		end
		end_sim();
	end
	initial begin
		// About 80000 cycles, several times the expected run
		#2000000;
		miscompares++;
		end_sim();
	end
endmodule
